// ---- verilog/vco_cal_and_channel_divider.sv ----
// Overview of operation
// [RQ1] calibration clock comes from dividing the reference tick stream
// [RQ2] with auto-calibrate strap and valid reference, commit and calibrate after reset
// [RQ3] software starts the first calibration by setting the request bit then updating
// [RQ4] later calibrations need request cleared, update, set, update: rising committed edge
// [RQ5] done status reads one once a calibration has finished
// [RQ6] calibration asserts sync, calibrates, releases sync, then closes the loop
// [RQ7] calibration clock is reference over ref count times 2, 4, 8 or 16
// [RQ8] one calibration lasts 4400 calibration clock cycles
// [RQ9] software keeps calibration clock under 6.25 MHz by divider choice
// [RQ10] no calibration starts on its own when loop settings change
// [RQ11] software requests calibration after loop divider or reference changes
// [RQ12] zero-delay mode 01 feeds selected channel divider back to feedback divider
// [RQ13] a two-bit field picks which of four channels supplies feedback
// [RQ14] zero-delay mode 11 feeds the external clock input back
// [RQ15] four channel dividers, all kept synchronized together
// [RQ16] pre-divider divides the divider input clock by 1 to 6
// [RQ17] output high for high count plus one, low for low count plus one
// [RQ18] duty correction, disableable, only when low count equals high count plus one
// [RQ19] coarse phase delay up to 15 input cycles per channel
// [RQ20] each channel chooses whether it starts high or low
// [RQ21] software disables holdover before requesting calibration
// [RQ22] bypass bit gives divide by one and stops the divider counters
// [RQ23] software never bypasses a channel while pre-divider ratio is one
// [RQ24] done status reads zero from calibration start until it completes
// [RQ25] staged settings reach the active logic only on the update strobe; the code also commits them on the power-up autocal strap
`default_nettype none
module vco_cal_and_channel_divider
   import clk_gen_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // staged settings and commit
   input wire pll_cfg_t pll_cfg_i,
   input wire chan_cfg_t [NUM_CHANNELS-1:0] chan_cfg_i,
   input wire logic update_i,
   // power-up straps and reference
   input wire logic autocal_strap_i,
   input wire logic ref_valid_i,
   input wire logic ref_tick_i,
   // feedback sources
   input wire logic normal_fb_i,
   input wire logic ext_clk_i,
   // calibration status
   output logic cal_done_o,
   output logic cal_busy_o,
   output logic output_sync_o,
   output logic loop_closed_o,
   // feedback path
   output logic [1:0] feedback_source_select_o,
   output logic feedback_o,
   // channel outputs
   output logic [NUM_CHANNELS-1:0] channel_clk_o,
   output logic [NUM_CHANNELS-1:0] duty_balance_correction_o
);

   // *****************************************
   // committed settings
   // *****************************************
   pll_cfg_t pll_cfg;
   pll_cfg_t next_pll_cfg;
   chan_cfg_t [NUM_CHANNELS-1:0] chan_cfg;
   chan_cfg_t [NUM_CHANNELS-1:0] next_chan_cfg;
   logic powerup_pending;
   logic next_powerup_pending;
   logic commit;
   logic cal_start;

   always_comb begin
      next_powerup_pending = 1'b0;
      // strap caught on the first clock after release, never inside reset
      commit = update_i || (powerup_pending && autocal_strap_i); // [RQ25] [RQ2]
      next_pll_cfg = pll_cfg;
      next_chan_cfg = chan_cfg;
      if (commit) begin
         next_pll_cfg = pll_cfg_i;
         next_chan_cfg = chan_cfg_i;
      end
      // only an explicit request edge or power-up autocal starts a run
      cal_start = (update_i && pll_cfg_i.cal_request && !pll_cfg.cal_request) || // [RQ4] [RQ3] [RQ10]
                  (powerup_pending && autocal_strap_i && ref_valid_i); // [RQ2]
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pll_cfg <= PLL_CFG_RST;
         chan_cfg <= {NUM_CHANNELS{CHAN_CFG_RST}};
         powerup_pending <= 1'b1;
      end else begin
         pll_cfg <= next_pll_cfg;
         chan_cfg <= next_chan_cfg;
         powerup_pending <= next_powerup_pending;
      end
   end

   // *****************************************
   // calibration clock divider
   // *****************************************
   logic [CAL_TICK_W-1:0] tick_cnt;
   logic [CAL_TICK_W-1:0] next_tick_cnt;
   logic [CAL_TICK_W-1:0] tick_target;
   logic [REF_COUNT_W-1:0] ref_div;
   logic cal_tick;

   always_comb begin
      ref_div = (pll_cfg.ref_count == '0) ? REF_COUNT_W'(1) : pll_cfg.ref_count;
      // ref count times 2 << sel gives R x cal_div reference ticks per cal clock
      tick_target = CAL_TICK_W'({ref_div, 1'b0} << pll_cfg.cal_div_sel); // [RQ7]
      cal_tick = 1'b0;
      next_tick_cnt = tick_cnt;
      if (!cal_busy_o) begin
         next_tick_cnt = '0;
      end else if (ref_tick_i) begin // [RQ1]
         if (tick_cnt == tick_target - CAL_TICK_W'(1)) begin
            next_tick_cnt = '0;
            cal_tick = 1'b1;
         end else begin
            next_tick_cnt = tick_cnt + CAL_TICK_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // *****************************************
   // calibration sequencer
   // *****************************************
   cal_state_t cal_state;
   cal_state_t next_cal_state;
   logic [CAL_CYCLE_W-1:0] cal_cnt;
   logic [CAL_CYCLE_W-1:0] next_cal_cnt;
   logic next_cal_done;
   logic next_output_sync;
   logic next_loop_closed;

   // a request that arrives mid-run is dropped: restarting would stretch sync
   always_comb begin
      next_cal_state = cal_state;
      next_cal_cnt = cal_cnt;
      next_cal_done = cal_done_o;
      next_output_sync = output_sync_o;
      next_loop_closed = loop_closed_o;
      unique case (cal_state)
         CAL_IDLE: begin
            if (cal_start) begin
               next_cal_state = CAL_RUN;
               next_cal_cnt = '0;
               next_cal_done = 1'b0; // [RQ24]
               next_output_sync = 1'b1; // [RQ6]
               next_loop_closed = 1'b0;
            end
         end
         CAL_RUN: begin
            if (cal_tick) begin
               if (cal_cnt == CAL_CYCLES - CAL_CYCLE_W'(1)) begin // [RQ8]
                  next_cal_state = CAL_RELEASE;
                  next_output_sync = 1'b0; // [RQ6]
               end else begin
                  next_cal_cnt = cal_cnt + CAL_CYCLE_W'(1);
               end
            end
         end
         CAL_RELEASE: begin
            next_cal_state = CAL_CLOSE;
            next_loop_closed = 1'b1; // [RQ6]
         end
         CAL_CLOSE: begin
            next_cal_state = CAL_IDLE;
            next_cal_done = 1'b1; // [RQ5]
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cal_state <= CAL_IDLE;
         cal_cnt <= '0;
         cal_done_o <= 1'b0;
         cal_busy_o <= 1'b0;
         output_sync_o <= 1'b0;
         loop_closed_o <= 1'b1;
      end else begin
         cal_state <= next_cal_state;
         cal_cnt <= next_cal_cnt;
         cal_done_o <= next_cal_done;
         cal_busy_o <= (next_cal_state != CAL_IDLE);
         output_sync_o <= next_output_sync;
         loop_closed_o <= next_loop_closed;
      end
   end

   // *****************************************
   // pre-divider
   // *****************************************
   logic [2:0] prediv_cnt;
   logic [2:0] next_prediv_cnt;
   logic [2:0] prediv_ratio;
   logic prediv_tick;

   always_comb begin
      // out-of-range ratios clamp rather than stall the channels
      prediv_ratio = pll_cfg.prediv_ratio;
      if (prediv_ratio < PREDIV_MIN) begin
         prediv_ratio = PREDIV_MIN;
      end else if (prediv_ratio > PREDIV_MAX) begin
         prediv_ratio = PREDIV_MAX;
      end
      prediv_tick = (prediv_cnt >= prediv_ratio - 3'h1); // [RQ16]
      next_prediv_cnt = prediv_tick ? 3'h0 : prediv_cnt + 3'h1;
      if (output_sync_o) begin
         next_prediv_cnt = 3'h0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prediv_cnt <= 3'h0;
      end else begin
         prediv_cnt <= next_prediv_cnt;
      end
   end

   // *****************************************
   // channel dividers
   // *****************************************
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
         logic [3:0] cnt;
         logic [3:0] next_cnt;
         logic [3:0] delay;
         logic [3:0] next_delay;
         logic next_level;
         logic next_dcc;
         chan_cfg_t cfg;

         always_comb begin
            cfg = chan_cfg[ch];
            next_cnt = cnt;
            next_delay = delay;
            next_level = channel_clk_o[ch];
            // all channels reload together under sync, so they restart aligned
            if (output_sync_o) begin // [RQ15]
               next_level = cfg.start_high; // [RQ20]
               next_cnt = cfg.start_high ? cfg.high_count : cfg.low_count;
               next_delay = cfg.phase_delay; // [RQ19]
            end else if (cfg.bypass) begin
               // counters frozen, output is the pre-divided input itself
               next_level = prediv_tick; // [RQ22]
            end else if (prediv_tick) begin
               if (delay != RST_COUNT) begin
                  next_delay = delay - 4'h1; // [RQ19]
               end else if (cnt == RST_COUNT) begin
                  next_level = !channel_clk_o[ch];
                  next_cnt = channel_clk_o[ch] ? cfg.low_count : cfg.high_count; // [RQ17]
               end else begin
                  next_cnt = cnt - 4'h1; // [RQ17]
               end
            end
            // only odd divides of the M=N+1 form get the half-cycle balance
            // compared one bit wider so high count 15 cannot wrap onto low count 0
            next_dcc = !cfg.dcc_disable && !cfg.bypass &&
                       ({1'b0, cfg.low_count} == {1'b0, cfg.high_count} + 5'h1); // [RQ18]
         end

         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               cnt <= RST_COUNT;
               delay <= RST_COUNT;
               channel_clk_o[ch] <= 1'b0;
               duty_balance_correction_o[ch] <= 1'b0;
            end else begin
               cnt <= next_cnt;
               delay <= next_delay;
               channel_clk_o[ch] <= next_level;
               duty_balance_correction_o[ch] <= next_dcc;
            end
         end
      end
   endgenerate

   // *****************************************
   // zero-delay feedback select
   // *****************************************
   logic [1:0] next_fb_select;
   logic next_feedback;

   always_comb begin
      unique case (pll_cfg.zd_mode)
         ZD_MODE_INTERNAL: begin
            next_fb_select = FB_SRC_CHANNEL; // [RQ12]
            next_feedback = channel_clk_o[pll_cfg.zd_channel]; // [RQ13]
         end
         ZD_MODE_EXTERNAL: begin
            next_fb_select = FB_SRC_EXTERNAL;
            next_feedback = ext_clk_i; // [RQ14]
         end
         default: begin
            next_fb_select = FB_SRC_NORMAL;
            next_feedback = normal_fb_i;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         feedback_source_select_o <= FB_SRC_NORMAL;
         feedback_o <= 1'b0;
      end else begin
         feedback_source_select_o <= next_fb_select;
         feedback_o <= next_feedback;
      end
   end

endmodule : vco_cal_and_channel_divider
`default_nettype wire

// ---- shared/clk_gen_pkg.sv ----
`default_nettype none
package clk_gen_pkg;
   // *****************************************
   // widths and counts
   // *****************************************
   localparam int NUM_CHANNELS = 4;
   localparam int REF_COUNT_W = 14;
   localparam int CAL_CYCLE_W = 13;
   localparam logic [CAL_CYCLE_W-1:0] CAL_CYCLES = 13'h1130; // 4400 calibration clocks
   localparam int CAL_TICK_W = 19;
   localparam logic [2:0] PREDIV_MIN = 3'h1;
   localparam logic [2:0] PREDIV_MAX = 3'h6;

   // *****************************************
   // encodings
   // *****************************************
   localparam logic [1:0] ZD_MODE_INTERNAL = 2'h1;
   localparam logic [1:0] ZD_MODE_EXTERNAL = 2'h3;
   localparam logic [1:0] FB_SRC_NORMAL = 2'h0;
   localparam logic [1:0] FB_SRC_CHANNEL = 2'h1;
   localparam logic [1:0] FB_SRC_EXTERNAL = 2'h3;

   // *****************************************
   // reset values
   // *****************************************
   localparam logic [3:0] RST_COUNT = 4'h0;

   typedef enum logic [1:0] {
      CAL_IDLE,
      CAL_RUN,
      CAL_RELEASE,
      CAL_CLOSE
   } cal_state_t;

   typedef struct packed {
      logic start_high;
      logic dcc_disable;
      logic bypass;
      logic [3:0] phase_delay;
      logic [3:0] high_count;
      logic [3:0] low_count;
   } chan_cfg_t;

   typedef struct packed {
      logic cal_request;
      logic [1:0] cal_div_sel;
      logic [REF_COUNT_W-1:0] ref_count;
      logic [1:0] zd_mode;
      logic [1:0] zd_channel;
      logic [2:0] prediv_ratio;
   } pll_cfg_t;

   localparam pll_cfg_t PLL_CFG_RST = '0;
   localparam chan_cfg_t CHAN_CFG_RST = '0;
endpackage : clk_gen_pkg
`default_nettype wire

// ---- verif/cal_monitor.sv ----
`default_nettype none
module cal_monitor
   import clk_gen_pkg::*;
(
   // block inputs
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire pll_cfg_t pll_cfg_i,
   input wire logic update_i,
   input wire logic autocal_strap_i,
   input wire logic ref_valid_i,
   input wire logic normal_fb_i,
   input wire logic ext_clk_i,
   // block outputs
   input wire logic cal_done_o,
   input wire logic cal_busy_o,
   input wire logic output_sync_o,
   input wire logic loop_closed_o,
   input wire logic [1:0] feedback_source_select_o,
   input wire logic feedback_o,
   input wire logic [NUM_CHANNELS-1:0] channel_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // **********
   // checks
   // **********
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   cal_tail_a:
      assert property ($fell(output_sync_o) |-> !loop_closed_o ##1 loop_closed_o && cal_busy_o
         ##1 cal_done_o && !cal_busy_o) else $error("bad calibration end");
   start_cause_a:
      assert property ($rose(cal_busy_o) |-> $past(update_i && pll_cfg_i.cal_request)
         || $past(autocal_strap_i && ref_valid_i)) else $error("unrequested start");
   sync_loop_a:
      assert property (output_sync_o |-> cal_busy_o && !loop_closed_o) else $error("loop closed in sync");
   done_low_a:
      assert property (output_sync_o |-> !cal_done_o) else $error("done in sync");
   // one cycle of grace for the start level to land
   static_out_a:
      assert property (output_sync_o && $past(output_sync_o, 2) |-> $stable(channel_clk_o))
         else $error("outputs move in sync");
   fb_ext_a:
      assert property ($past(rstn_i) && feedback_source_select_o == FB_SRC_EXTERNAL
         && $stable(feedback_source_select_o) |-> feedback_o == $past(ext_clk_i)) else $error("bad ext feedback");
   fb_norm_a:
      assert property ($past(rstn_i) && feedback_source_select_o == FB_SRC_NORMAL
         && $stable(feedback_source_select_o) |-> feedback_o == $past(normal_fb_i)) else $error("bad feedback");
   fb_code_a:
      assert property (feedback_source_select_o != 2'h2) else $error("bad feedback code");
   cover property ($fell(output_sync_o));
   cover property ($rose(cal_busy_o) && !$past(update_i));
   cover property (feedback_source_select_o == FB_SRC_CHANNEL);
endmodule : cal_monitor
bind vco_cal_and_channel_divider cal_monitor cal_monitor_i (.*);
`default_nettype wire

// ---- verif/testbench.sv ----
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
   $display("wrong value %s exp %0h got %0h", nm, e, s); end end
module testbench
   import clk_gen_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // **********
   // bench
   // **********
   logic clk, rst_n = 0, update_i = 0, autocal_strap_i = 1, ref_valid_i = 1, ref_tick_i = 1;
   logic normal_fb_i = 0, ext_clk_i = 0, rt = 0, ps = 0, e;
   logic cal_done_o, cal_busy_o, output_sync_o, loop_closed_o, feedback_o;
   logic [1:0] feedback_source_select_o;
   logic [3:0] cclk, duty_balance_correction_o;
   pll_cfg_t pc = '0;
   chan_cfg_t [NUM_CHANNELS-1:0] cc = '0;
   // second lfsr keeps background traffic off the main draw order
   logic [31:0] r = 32'hfe08, bg = 32'hfe08;
   int bad_count = 0, checks = 0, cyc = 0, nt = 0, p, hi, lo;
   int rise [4];
   vco_cal_and_channel_divider vco_cal_and_channel_divider_i (.core_clk_i(clk), .rstn_i(rst_n),
      .pll_cfg_i(pc), .chan_cfg_i(cc), .channel_clk_o(cclk), .*);
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nx
   function automatic int cal_len();
      return 4400 * pc.ref_count * (2 << pc.cal_div_sel);
   endfunction : cal_len
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic commit();
      @(negedge clk) update_i = 1;
      @(negedge clk) update_i = 0;
      @(negedge clk);
   endtask : commit
   task automatic cal(input bit again);
      int n;
      n = cal_len();
      `CHK("busy", 1'b1, cal_busy_o)
      `CHK("done", 1'b0, cal_done_o)
      @(negedge clk);
      `CHK("start", {cc[3].start_high, cc[2].start_high, cc[1].start_high, cc[0].start_high}, cclk)
      if (again) commit();
      while (output_sync_o) @(negedge clk);
      `CHK("ticks", n, nt)
      repeat (2) @(negedge clk);
      `CHK("done", 1'b1, cal_done_o)
      $display("calibration test over");
   endtask : cal
   // unbounded looking waits are cut by the global ceiling
   task automatic meas(input int c);
      while (cclk[c]) @(negedge clk);
      while (!cclk[c]) @(negedge clk);
      for (hi = 0; cclk[c]; hi++) @(negedge clk);
      for (lo = 0; !cclk[c]; lo++) @(negedge clk);
   endtask : meas
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (output_sync_o && !ps) nt = 0;
      if (output_sync_o && ref_tick_i) nt++;
      ps = output_sync_o;
      for (int c = 0; c < 4; c++) rise[c] = output_sync_o ? 0 : (rise[c] == 0 && cclk[c]) ? cyc : rise[c];
      if (cyc == 80000) begin
         bad_count++;
         give_verdict();
      end
   end
   always @(negedge clk) begin
      bg = nx(bg);
      ref_tick_i <= rt ? bg[3] : 1'b1;
      normal_fb_i <= bg[5];
      ext_clk_i <= bg[9];
   end
   initial begin
      r = nx(r);
      p = r % 6 + 1;
      pc.ref_count = 14'h1;
      pc.prediv_ratio = 3'(p);
      for (int c = 0; c < 4; c++) cc[c] = {3'h0, 4'(c * 5), 8'h77};
      repeat (20) @(negedge clk);
      rst_n = 1;
      @(negedge clk);
      autocal_strap_i = 0;
      cal(0);
      repeat (300) @(negedge clk);
      for (int c = 1; c < 4; c++) `CHK("delay", c * 5 * p, rise[c] - rise[0])
      pc.ref_count = 14'h2;
      commit();
      `CHK("idle", 1'b0, cal_busy_o)
      // holdover is not part of this block, so nothing to switch off first
      pc.ref_count = 14'h1;
      pc.cal_request = 1;
      pc.cal_div_sel = 2'h1;
      rt = 1;
      commit();
      cal(1);
      rt = 0;
      commit();
      `CHK("idle", 1'b0, cal_busy_o)
      pc.cal_request = 0;
      commit();
      pc.cal_request = 1;
      pc.cal_div_sel = 2'h0;
      commit();
      cal(0);
      for (int m = 0; m < 4; m++) begin
         r = nx(r);
         pc.zd_mode = 2'(m);
         pc.zd_channel = r[1:0];
         commit();
         @(negedge clk);
         `CHK("select", m == 1 ? FB_SRC_CHANNEL : m == 3 ? FB_SRC_EXTERNAL : FB_SRC_NORMAL,
            feedback_source_select_o)
         repeat (30) begin
            e = cclk[r[1:0]];
            @(negedge clk);
            `CHK("feedback", m == 1 ? e : m == 3 ? ext_clk_i : normal_fb_i, feedback_o)
         end
      end
      $display("feedback test over");
      for (int t = 0; t < 3; t++) begin
         r = nx(r);
         p = t == 0 ? 1 : r % 5 + 2;
         pc.prediv_ratio = 3'(p);
         for (int c = 0; c < 4; c++) begin
            r = nx(r);
            cc[c] = r[14:0];
            cc[c].bypass = c == 3 && p > 1;
            cc[c].high_count[3] = 1'b0;
            if (c == 1) cc[c].low_count = cc[c].high_count + 4'h1;
         end
         commit();
         repeat (400) @(negedge clk);
         for (int c = 0; c < 4; c++) begin
            meas(c);
            `CHK("high", cc[c].bypass ? 1 : (cc[c].high_count + 1) * p, hi)
            `CHK("low", cc[c].bypass ? p - 1 : (cc[c].low_count + 1) * p, lo)
            if (!cc[c].bypass)
               `CHK("duty", !cc[c].dcc_disable && cc[c].low_count == cc[c].high_count + 1,
                  duty_balance_correction_o[c])
         end
         $display("divider trial %0d over", t);
      end
      // mid-run reset with the strap set but no reference: no power-up calibration
      ref_valid_i = 0;
      autocal_strap_i = 1;
      rst_n = 0;
      repeat (3) @(negedge clk);
      rst_n = 1;
      repeat (3) @(negedge clk);
      `CHK("no ref", 1'b0, cal_busy_o)
      `CHK("done rst", 1'b0, cal_done_o)
      $display("reset test over");
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
